// file: verilog/stoil_cfg.svh
// Constants of the torque-off interlock: offsets, fields, resets, timing.
// Assumes a 25 MHz pclk and a byte-addressed APB with 32-bit data.
`ifndef STOIL_CFG_SVH
`define STOIL_CFG_SVH
`define STOIL_CLK_HZ      25000000
`define STOIL_SKEW_S      10
`define STOIL_SKEW_CYC    (`STOIL_SKEW_S * `STOIL_CLK_HZ)
`define STOIL_MS_CYC      (`STOIL_CLK_HZ / 1000)
`define STOIL_SEC_CYC     (`STOIL_CLK_HZ)
`define STOIL_HOUR_S      32'h0000_0E10
`define STOIL_OFF_CTRL    12'h000
`define STOIL_OFF_BRKDLY  12'h004
`define STOIL_OFF_STATUS  12'h008
`define STOIL_OFF_IRQST   12'h00C
`define STOIL_OFF_IRQCLR  12'h010
`define STOIL_OFF_IRQEN   12'h014
`define STOIL_OFF_LOGSEL  12'h018
`define STOIL_OFF_LOGDAT  12'h01C
`define STOIL_CTRL_CLRH   4
`define STOIL_CTRL_ARST   5
`define STOIL_IRQ_SKEW    0
`define STOIL_IRQ_TOFF    1
`define STOIL_IRQ_LOG     2
`define STOIL_RST_STOP    4'h0
`define STOIL_RST_BRKDLY  16'h0000
`define STOIL_SKEW_CODE   8'hE1
`define STOIL_LOG_DEPTH   8
`endif

// file: verilog/stoil_pkg.sv
// Types of the torque-off interlock.
// Assumes nothing beyond a SystemVerilog compiler.
package stoil_pkg;
    typedef enum logic [1:0]
    {
        ST_TORQUE_OFF  = 2'b00,
        ST_DRIVE_READY = 2'b01,
        ST_SERVO_READY = 2'b10
    } stoil_state_t;
endpackage : stoil_pkg

// file: verilog/stoil_top.sv
// Safe torque-off interlock: input sync, drive state, brake, monitor,
// skew alarm, alarm history and APB registers.
// Assumes inputs high = ON and a single pclk domain.
//
// Notes on behaviour
// R1: Both inputs off: power off within 7 ms.
// R2: In torque-off, drive-ready stays low.
// R3: Drive-ready only if both on, servo-on off.
// R4: Torque-off drops brake release, ignores delay.
// R5: Torque-off stops by method; 0/1 dynamic brake.
// R6: Monitor output high only when both off.
// R7: Skew alarm never blocks torque-off.
// R8: Same alarm within one hour logged once.
// R9: History kept until explicit clear command.
// R10: Controller should stop motor before torque-off.
// R11: Controller reasserts servo-on after inputs return.
// R12: Both inputs off enters torque-off.
// R13: Servo-on held through torque-off blocks recovery.
// R14: Inputs disagree over 10 s: skew alarm.
// R15: Inputs synchronised; intervals timed by counters.
//
// Local design decisions: the placing of the registers and register access over APB.
`include "stoil_cfg.svh"

module stoil_top #(
    parameter int unsigned SKEW_CYC = `STOIL_SKEW_CYC,
    parameter int unsigned MS_CYC   = `STOIL_MS_CYC,
    parameter int unsigned SEC_CYC  = `STOIL_SEC_CYC
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        safe_input_a,
    input  wire logic        safe_input_b,
    input  wire logic        servo_on_req,
    input  wire logic        alarm_event,
    input  wire logic [7:0]  alarm_code,
    output logic             motor_power_en,
    output logic             drive_ready_out,
    output logic             brake_release_out,
    output logic             dyn_brake_out,
    output logic             device_monitor_out,
    output logic             input_skew_alarm,
    output stoil_pkg::stoil_state_t torque_state,
    output logic             irq
);
    import stoil_pkg::*;

    localparam int DEPTH = `STOIL_LOG_DEPTH;

    ////////////////////////////////////////////////////////////////////////
    // Input synchronisers; stage 1 is read only by stage 2
    logic [2:0] sync1_r;
    logic [2:0] sync2_r;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sync1_r <= 3'h0;
            sync2_r <= 3'h0;
        end
        else
        begin
            sync1_r <= {servo_on_req, safe_input_b, safe_input_a}; // [R15]
            sync2_r <= sync1_r;
        end
    end
    wire in_a     = sync2_r[0];
    wire in_b     = sync2_r[1];
    wire son      = sync2_r[2];
    wire both_on  = in_a & in_b;
    wire both_off = ~in_a & ~in_b;

    ////////////////////////////////////////////////////////////////////////
    // Registers
    logic [3:0]  stop_method_setting;
    logic [15:0] brake_delay_setting;
    logic [2:0]  irq_st_r;
    logic [2:0]  irq_en_r;
    logic [2:0]  log_sel_r;

    wire wr_en   = psel & penable & pwrite;
    wire setup   = psel & ~penable;
    wire a_ctrl  = paddr == `STOIL_OFF_CTRL;
    wire a_bdly  = paddr == `STOIL_OFF_BRKDLY;
    wire a_stat  = paddr == `STOIL_OFF_STATUS;
    wire a_ist   = paddr == `STOIL_OFF_IRQST;
    wire a_iclr  = paddr == `STOIL_OFF_IRQCLR;
    wire a_ien   = paddr == `STOIL_OFF_IRQEN;
    wire a_lsel  = paddr == `STOIL_OFF_LOGSEL;
    wire a_ldat  = paddr == `STOIL_OFF_LOGDAT;
    wire mapped  = a_ctrl | a_bdly | a_stat | a_ist | a_iclr | a_ien | a_lsel | a_ldat;
    wire clr_hist  = wr_en & a_ctrl & pwdata[`STOIL_CTRL_CLRH];
    wire alarm_rst = wr_en & a_ctrl & pwdata[`STOIL_CTRL_ARST];

    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~mapped;

    ////////////////////////////////////////////////////////////////////////
    // Drive state machine
    stoil_state_t state_r;
    stoil_state_t state_nxt;
    always_comb
    begin
        state_nxt = state_r;
        unique case (state_r)
            ST_TORQUE_OFF:
                if (both_on && !son)
                    state_nxt = ST_DRIVE_READY;          // [R13]
            ST_DRIVE_READY:
                if (both_off)
                    state_nxt = ST_TORQUE_OFF;           // [R12]
                else if (son)
                    state_nxt = ST_SERVO_READY;
            ST_SERVO_READY:
                if (both_off)
                    state_nxt = ST_TORQUE_OFF;           // [R12] [R7]
                else if (!son)
                    state_nxt = ST_DRIVE_READY;
            default:
                state_nxt = ST_TORQUE_OFF;
        endcase
    end
    wire enter_toff = (state_nxt == ST_TORQUE_OFF) && (state_r != ST_TORQUE_OFF);

    // Millisecond tick for the brake-to-servo-off delay
    logic [31:0] ms_cnt_r;
    logic [15:0] bdly_cnt_r;
    wire ms_tick = ms_cnt_r == MS_CYC - 1;
    wire servo_off = (state_r == ST_SERVO_READY) && (state_nxt == ST_DRIVE_READY);
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_r    <= ST_TORQUE_OFF;
            ms_cnt_r   <= 32'h0;
            bdly_cnt_r <= 16'h0;
        end
        else
        begin
            state_r  <= state_nxt;
            ms_cnt_r <= ms_tick ? 32'h0 : ms_cnt_r + 32'h1;
            if (state_nxt == ST_TORQUE_OFF)
                bdly_cnt_r <= 16'h0;                     // [R4]
            else if (servo_off)
                bdly_cnt_r <= brake_delay_setting;
            else if (ms_tick && bdly_cnt_r != 16'h0)
                bdly_cnt_r <= bdly_cnt_r - 16'h1;
        end
    end

    // Outputs from flops; power falls one cycle after both inputs settle off
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            motor_power_en     <= 1'b0;
            drive_ready_out    <= 1'b0;
            brake_release_out  <= 1'b0;
            dyn_brake_out      <= 1'b0;
            device_monitor_out <= 1'b0;
        end
        else
        begin
            motor_power_en     <= (state_nxt == ST_SERVO_READY) ||
                                  (state_nxt == ST_DRIVE_READY && bdly_cnt_r != 16'h0 &&
                                   !servo_off) || servo_off; // [R1]
            drive_ready_out    <= (state_nxt != ST_TORQUE_OFF) && both_on && !son; // [R2] [R3]
            brake_release_out  <= state_nxt == ST_SERVO_READY; // [R4]
            dyn_brake_out      <= (state_nxt == ST_TORQUE_OFF) &&
                                  (stop_method_setting <= 4'h1); // [R5]
            device_monitor_out <= both_off;              // [R6]
        end
    end
    assign torque_state = state_r;

    ////////////////////////////////////////////////////////////////////////
    // Input skew detection; diagnostic only
    logic [31:0] skew_cnt_r;
    logic        skew_hit;
    assign skew_hit = (in_a != in_b) && (skew_cnt_r == SKEW_CYC - 1);
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            skew_cnt_r       <= 32'h0;
            input_skew_alarm <= 1'b0;
        end
        else
        begin
            if (in_a == in_b)
                skew_cnt_r <= 32'h0;
            else if (skew_cnt_r != SKEW_CYC)
                skew_cnt_r <= skew_cnt_r + 32'h1;        // [R14]
            if (skew_hit)
                input_skew_alarm <= 1'b1;                // [R14] [R7]
            else if (alarm_rst)
                input_skew_alarm <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Alarm history with one-hour suppression of repeats
    logic [31:0] sec_cnt_r;
    logic [31:0] now_s_r;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sec_cnt_r <= 32'h0;
            now_s_r   <= 32'h0;
        end
        else if (sec_cnt_r == SEC_CYC - 1)
        begin
            sec_cnt_r <= 32'h0;
            now_s_r   <= now_s_r + 32'h1;
        end
        else
            sec_cnt_r <= sec_cnt_r + 32'h1;
    end

    // Storage has no reset so a drive reset leaves the history in place
    logic [7:0]  log_code [DEPTH];
    logic [31:0] log_time [DEPTH];
    logic [DEPTH-1:0] log_vld;
    logic [2:0]  log_wp;

    wire       new_alarm = skew_hit | alarm_event;
    wire [7:0] new_code  = skew_hit ? `STOIL_SKEW_CODE : alarm_code;
    logic [DEPTH-1:0] recent;
    genvar gi;
    generate
        for (gi = 0; gi < DEPTH; gi++)
        begin : g_dup
            assign recent[gi] = log_vld[gi] && log_code[gi] == new_code &&
                                (now_s_r - log_time[gi]) < `STOIL_HOUR_S; // [R8]
        end
    endgenerate
    wire log_wr = new_alarm && (recent == '0) && !clr_hist; // [R8]

    always_ff @(posedge pclk)
    begin
        if (clr_hist)
        begin
            log_vld <= '0;                               // [R9]
            log_wp  <= 3'h0;
        end
        else if (log_wr)
        begin
            log_code[log_wp] <= new_code;
            log_time[log_wp] <= now_s_r;
            log_vld[log_wp]  <= 1'b1;
            log_wp           <= log_wp + 3'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupt and register writes; hardware set beats software clear
    wire [2:0] irq_ev  = {log_wr, enter_toff, skew_hit};
    wire [2:0] irq_clr = (wr_en && a_iclr) ? pwdata[2:0] : 3'h0;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            stop_method_setting <= `STOIL_RST_STOP;
            brake_delay_setting <= `STOIL_RST_BRKDLY;
            irq_st_r            <= 3'h0;
            irq_en_r            <= 3'h0;
            log_sel_r           <= 3'h0;
        end
        else
        begin
            irq_st_r <= (irq_st_r & ~irq_clr) | irq_ev;
            if (wr_en && a_ctrl)
                stop_method_setting <= pwdata[3:0];
            if (wr_en && a_bdly)
                brake_delay_setting <= pwdata[15:0];
            if (wr_en && a_ien)
                irq_en_r <= pwdata[2:0];
            if (wr_en && a_lsel)
                log_sel_r <= pwdata[2:0];
        end
    end
    assign irq = |(irq_st_r & irq_en_r);

    ////////////////////////////////////////////////////////////////////////
    // Read data latched in the setup cycle
    wire [31:0] rd_stat = {22'h0, bdly_cnt_r != 16'h0, motor_power_en, input_skew_alarm,
                           device_monitor_out, son, in_b, in_a, dyn_brake_out, state_r};
    wire [31:0] rd_log  = {log_vld[log_sel_r], 7'h0, log_code[log_sel_r],
                           log_time[log_sel_r][15:0]};
    wire [31:0] rd_mux  = a_ctrl ? {28'h0, stop_method_setting} :
                          a_bdly ? {16'h0, brake_delay_setting} :
                          a_stat ? rd_stat :
                          a_ist  ? {29'h0, irq_st_r} :
                          a_ien  ? {29'h0, irq_en_r} :
                          a_lsel ? {29'h0, log_sel_r} :
                          a_ldat ? rd_log : 32'h0;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h0;
        else if (setup && !pwrite)
            prdata <= rd_mux;
    end
endmodule : stoil_top

// file: testbench/stoil_checker.sv
// Port checker of the torque-off interlock.
// Assumes the top module's ports; bound below.
module stoil_checker #(
    parameter int unsigned SKEW_CYC = 200
) (
    input wire logic               pclk,
    input wire logic               presetn,
    input wire logic               safe_input_a,
    input wire logic               safe_input_b,
    input wire logic               servo_on_req,
    input wire logic               motor_power_en,
    input wire logic               drive_ready_out,
    input wire logic               brake_release_out,
    input wire logic               device_monitor_out,
    input wire logic               input_skew_alarm,
    input wire stoil_pkg::stoil_state_t torque_state
);
    timeunit 1ns;
    timeprecision 1ns;
    import stoil_pkg::*;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [31:0] skew_r;
    logic [31:0] skew_nxt;
    // Margin of 8 covers the sync flops; saturates so it cannot wrap
    assign skew_nxt = (safe_input_a == safe_input_b) ? 32'h0 :
                      (skew_r < SKEW_CYC + 8) ? skew_r + 32'h1 : skew_r;
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
            skew_r <= 32'h0;
        else
            skew_r <= skew_nxt;
    ////////////////////////////////////////////////////////////////////////
    sequence both_off_s;
        (!safe_input_a && !safe_input_b) [*4];
    endsequence
    sequence any_on_s;
        (safe_input_a || safe_input_b) [*4];
    endsequence
    power_cut_a: assert property (both_off_s |=> !motor_power_en
        && torque_state == ST_TORQUE_OFF) else $error("power not cut");
    ready_block_a: assert property (torque_state == ST_TORQUE_OFF
        |-> !drive_ready_out) else $error("ready in torque-off");
    brake_drop_a: assert property (torque_state == ST_TORQUE_OFF
        |-> !brake_release_out && !motor_power_en) else $error("brake held");
    monitor_on_a: assert property (both_off_s
        |=> device_monitor_out) else $error("monitor low");
    monitor_off_a: assert property (any_on_s
        |=> !device_monitor_out) else $error("monitor high");
    skew_safe_a: assert property (input_skew_alarm ##0 both_off_s
        |=> torque_state == ST_TORQUE_OFF) else $error("skew blocked stop");
    hold_off_a: assert property ((torque_state == ST_TORQUE_OFF
        && servo_on_req) [*4] |=> torque_state == ST_TORQUE_OFF)
        else $error("left torque-off");
    skew_alarm_a: assert property (skew_r == SKEW_CYC + 8
        |-> input_skew_alarm) else $error("no skew alarm");
endmodule : stoil_checker
bind stoil_top stoil_checker #(.SKEW_CYC(SKEW_CYC)) u_chk (.pclk, .presetn,
    .safe_input_a, .safe_input_b, .servo_on_req, .motor_power_en,
    .drive_ready_out, .brake_release_out, .device_monitor_out,
    .input_skew_alarm, .torque_state);

// file: testbench/stoil_partner.sv
// Safety module and host controller driving the drive's inputs.
// Assumes bench commands; changes just after pclk edges.
module stoil_partner (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic guard_open,
    input  wire logic lag_b,
    input  wire logic son_cmd,
    output logic      safe_input_a,
    output logic      safe_input_b,
    output logic      servo_on_req
);
    timeunit 1ns;
    timeprecision 1ns;
    // Channels off in reset: the safe default
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
        begin
            safe_input_a <= 1'b0;
            safe_input_b <= 1'b0;
            servo_on_req <= 1'b0;
        end
        else
        begin
            safe_input_a <= !guard_open;
            safe_input_b <= !(guard_open && !lag_b);
            servo_on_req <= son_cmd;
        end
endmodule : stoil_partner

// file: testbench/tb_stoil_top.sv
// Bench of the torque-off interlock: APB master, partner, scenarios.
// Assumes short timing parameters so one hour fits in the run.
`include "stoil_cfg.svh"
module tb_stoil_top;
    timeunit 1ns;
    timeprecision 1ns;
    import stoil_pkg::*;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic        guard = 1'b1;
    logic        lag = 1'b0;
    logic        son = 1'b0;
    logic        alarm_event = 1'b0;
    logic [7:0]  alarm_code = 8'h00;
    logic [31:0] prdata, q;
    logic        pready, pslverr, err, safe_input_a, safe_input_b, servo_on_req;
    logic        motor_power_en, drive_ready_out, brake_release_out, dyn_brake_out;
    logic        device_monitor_out, input_skew_alarm, irq;
    stoil_state_t torque_state;
    int          n_errors = 0;
    int          checked = 0;
    stoil_partner u_partner (.pclk, .presetn, .guard_open(guard), .lag_b(lag),
        .son_cmd(son), .safe_input_a, .safe_input_b, .servo_on_req);
    stoil_top #(.SKEW_CYC(200), .MS_CYC(10), .SEC_CYC(20)) u_dut (.pclk, .presetn,
        .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .safe_input_a, .safe_input_b, .servo_on_req, .alarm_event, .alarm_code,
        .motor_power_en, .drive_ready_out, .brake_release_out, .dyn_brake_out,
        .device_monitor_out, .input_skew_alarm, .torque_state, .irq);
    initial
        forever #20 pclk = ~pclk;
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            n_errors++;
            $display("unexpected %s: expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask : cyc
    task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // One more edge so callers see what the write changed, not the old value
        @(posedge pclk);
    endtask : apb
    // Partner takes one edge, the drive three more
    task automatic drive(input logic g, input logic l, input logic s);
        @(posedge pclk);
        guard <= g;
        lag <= l;
        son <= s;
        cyc(8);
    endtask : drive
    task automatic rdlog(input logic [2:0] i);
        apb(1'b1, `STOIL_OFF_LOGSEL, {29'h0, i});
        apb(1'b0, `STOIL_OFF_LOGDAT, 32'h0);
    endtask : rdlog
    task automatic pulse(input logic [7:0] c);
        @(posedge pclk);
        alarm_event <= 1'b1;
        alarm_code <= c;
        @(posedge pclk);
        alarm_event <= 1'b0;
        cyc(3);
    endtask : pulse
    ////////////////////////////////////////////////////////////////////////
    task automatic t_stop();
        apb(1'b1, `STOIL_OFF_BRKDLY, 32'h5);
        apb(1'b0, `STOIL_OFF_BRKDLY, 32'h0);
        chk("brkdly", q, 32'h5);
        drive(1'b0, 1'b0, 1'b0);
        chk("ready", drive_ready_out, 1);
        for (int m = 0; m < 3; m++)
        begin
            drive(1'b0, 1'b0, 1'b1);
            chk("power", motor_power_en, 1);
            chk("release", brake_release_out, 1);
            apb(1'b1, `STOIL_OFF_CTRL, m);
            drive(1'b1, 1'b0, 1'b1);
            chk("state", torque_state, ST_TORQUE_OFF);
            chk("brake", brake_release_out, 0);
            chk("cutoff", motor_power_en, 0);
            chk("dyn", dyn_brake_out, m <= 1);
            chk("monitor", device_monitor_out, 1);
            drive(1'b0, 1'b0, 1'b1);
            chk("held", torque_state, ST_TORQUE_OFF);
            chk("noready", drive_ready_out, 0);
            // Servo-on released so recovery passes through drive-ready
            drive(1'b0, 1'b0, 1'b0);
            chk("rdy", torque_state, ST_DRIVE_READY);
        end
        apb(1'b0, `STOIL_OFF_IRQST, 32'h0);
        chk("irqst", q[1], 1);
        chk("masked", irq, 0);
        apb(1'b1, `STOIL_OFF_IRQEN, 32'h2);
        chk("irqon", irq, 1);
        apb(1'b1, `STOIL_OFF_IRQCLR, 32'h2);
        chk("irqclr", irq, 0);
        // Motor stopped by servo-off with the guard closed: brake at once, power after the delay
        drive(1'b0, 1'b0, 1'b1);
        drive(1'b0, 1'b0, 1'b0);
        chk("bkoff", brake_release_out, 0);
        chk("dlypwr", motor_power_en, 1);
        cyc(60);
        chk("dlyend", motor_power_en, 0);
    endtask : t_stop
    task automatic t_skew();
        drive(1'b0, 1'b0, 1'b1);
        drive(1'b1, 1'b1, 1'b1);
        chk("onecut", device_monitor_out, 0);
        chk("stay", torque_state, ST_SERVO_READY);
        cyc(210);
        chk("skew", input_skew_alarm, 1);
        apb(1'b0, `STOIL_OFF_STATUS, 32'h0);
        chk("status", q[7:3], 5'h16);
        drive(1'b1, 1'b0, 1'b1);
        chk("cut", motor_power_en, 0);
        apb(1'b1, `STOIL_OFF_CTRL, 32'h20);
        chk("alrst", input_skew_alarm, 0);
    endtask : t_skew
    task automatic t_log();
        rdlog(3'h0);
        chk("log0", {q[31], q[23:16]}, {1'b1, `STOIL_SKEW_CODE});
        pulse(8'h30);
        pulse(8'h30);
        rdlog(3'h2);
        chk("dup", q[31], 0);
        cyc(72100);
        pulse(8'h30);
        rdlog(3'h2);
        chk("late", {q[31], q[23:16]}, 9'h130);
        @(posedge pclk);
        presetn <= 1'b0;
        cyc(2);
        presetn <= 1'b1;
        rdlog(3'h0);
        chk("kept", q[31], 1);
        apb(1'b1, `STOIL_OFF_CTRL, 32'h10);
        rdlog(3'h0);
        chk("cleared", q[31], 0);
    endtask : t_log
    task automatic wrap_up();
        if (n_errors == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : wrap_up
    initial
    begin
        cyc(16);
        presetn <= 1'b1;
        apb(1'b1, `STOIL_OFF_CTRL, 32'h10);
        apb(1'b0, 12'h040, 32'h0);
        chk("slverr", err, 1);
        chk("unmapped", q, 0);
        t_stop();
        t_skew();
        t_log();
        wrap_up();
    end
    initial
    begin
        #4000000;
        n_errors++;
        wrap_up();
    end
endmodule : tb_stoil_top
